// [include/adcr_cfg.svh]
// constants for the aperture coarse delay register block
`ifndef ADCR_CFG_SVH
`define ADCR_CFG_SVH

`define ADCR_ADDR_W        12
`define ADCR_REG_W         16
`define ADCR_CODE_W        12
`define ADCR_FINE_W        6
`define ADCR_FS_W          20

`define ADCR_OFS_COARSE    12'h00c
`define ADCR_OFS_STATUS    12'h010

`define ADCR_COARSE_RESET  16'h0004
`define ADCR_CODE_HI       15
`define ADCR_CODE_LO       4
`define ADCR_SEL_BIT       3
`define ADCR_DCC_BIT       2
`define ADCR_RSVD_HI       1
`define ADCR_RSVD_LO       0

`define ADCR_STS_SEL_BIT   3
`define ADCR_STS_FINE_BIT  2
`define ADCR_STS_SAT_BIT   1
`define ADCR_STS_IGN_BIT   0

`define ADCR_CODE_MAX      12'd2431
`define ADCR_STEP_FS       20'd340
`define ADCR_FINE_STEP_FS  20'd36
`define ADCR_MAX_DELAY_PS  825

`endif

// [include/adcr_pkg.sv]
// types shared by the coarse delay register block
`include "adcr_cfg.svh"

package adcr_pkg;

    typedef enum logic [1:0] {
        ADCR_SRC_NONE  = 2'b00,
        ADCR_SRC_LOCAL = 2'b01,
        ADCR_SRC_FINE  = 2'b10
    } adcr_src_t;

    typedef logic [`ADCR_CODE_W-1:0] adcr_code_t;
    typedef logic [`ADCR_FINE_W-1:0] adcr_fine_t;
    typedef logic [`ADCR_FS_W-1:0]   adcr_fs_t;
    typedef logic [`ADCR_REG_W-1:0]  adcr_word_t;

endpackage

// [include/adcr_reg_if.sv]
// carrier between the bus front end and the register storage
`timescale 1ns/1ps

interface adcr_reg_if;
    import adcr_pkg::*;

    logic       wr_en;
    adcr_word_t wr_data;
    adcr_code_t code;
    logic       sel;
    logic       dcc;
    adcr_word_t rd_word;

    modport owner (
        input  wr_en,
        input  wr_data,
        output code,
        output sel,
        output dcc,
        output rd_word
    );

    modport user (
        output wr_en,
        output wr_data,
        input  code,
        input  sel,
        input  dcc,
        input  rd_word
    );
endinterface

// [core/adcr_regcell.sv]
// storage of the coarse delay register fields
`timescale 1ns/1ps

module adcr_regcell
    import adcr_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    adcr_reg_if.owner   rif
);

    localparam adcr_word_t RESET_WORD = `ADCR_COARSE_RESET;

    adcr_code_t code;
    logic       sel;
    logic       dcc;
    adcr_code_t next_code;
    logic       next_sel;
    logic       next_dcc;

    always_comb begin
        next_code = code;
        next_sel  = sel;
        next_dcc  = dcc;
        if (rif.wr_en) begin
            next_code = rif.wr_data[`ADCR_CODE_HI:`ADCR_CODE_LO];
            next_sel  = rif.wr_data[`ADCR_SEL_BIT];
            next_dcc  = rif.wr_data[`ADCR_DCC_BIT];
        end
    end

    // reserved bits are never stored, so they cannot leak into readback
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code <= RESET_WORD[`ADCR_CODE_HI:`ADCR_CODE_LO];
            sel  <= RESET_WORD[`ADCR_SEL_BIT];
            dcc  <= RESET_WORD[`ADCR_DCC_BIT];
        end else begin
            code <= next_code;
            sel  <= next_sel;
            dcc  <= next_dcc;
        end
    end

    assign rif.code    = code;
    assign rif.sel     = sel;
    assign rif.dcc     = dcc;
    assign rif.rd_word = {code, sel, dcc, 2'b00};

endmodule

// [core/adcr_top.sv]
// apb front end and delay control of the aperture coarse delay register
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module adcr_top
    import adcr_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`ADCR_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     fine_reg_delay_select,
    input  wire logic [`ADCR_FINE_W-1:0]  fine_delay_code,
    output logic      [`ADCR_CODE_W-1:0]  applied_coarse_code,
    output logic      [`ADCR_FINE_W-1:0]  applied_fine_code,
    output logic                          delay_path_en,
    output logic                          duty_cycle_stabilizer_en,
    output logic      [`ADCR_FS_W-1:0]    applied_delay_fs
);

    adcr_reg_if rif ();

    adcr_regcell u_regcell (
        .pclk    (pclk),
        .presetn (presetn),
        .rif     (rif.owner)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // word-aligned match; the two byte-offset bits are not decoded
    function automatic logic addr_hit(
        input logic [`ADCR_ADDR_W-1:0] addr,
        input logic [`ADCR_ADDR_W-1:0] ofs
    );
        addr_hit = (addr[`ADCR_ADDR_W-1:2] == ofs[`ADCR_ADDR_W-1:2]);
    endfunction

    // codes past the top of the delay line hold at the top
    function automatic adcr_code_t sat_code(input adcr_code_t code);
        if (code > `ADCR_CODE_MAX) begin
            sat_code = `ADCR_CODE_MAX;
        end else begin
            sat_code = code;
        end
    endfunction

    function automatic logic is_sat(input adcr_code_t code);
        is_sat = (code > `ADCR_CODE_MAX);
    endfunction

    // nominal delay only; the analog line spreads by process and temperature
    function automatic adcr_fs_t delay_fs(
        input adcr_code_t coarse,
        input adcr_fine_t fine
    );
        adcr_fs_t c_ext;
        adcr_fs_t f_ext;
        c_ext    = {{(`ADCR_FS_W-`ADCR_CODE_W){1'b0}}, coarse};
        f_ext    = {{(`ADCR_FS_W-`ADCR_FINE_W){1'b0}}, fine};
        delay_fs = adcr_fs_t'(c_ext * `ADCR_STEP_FS + f_ext * `ADCR_FINE_STEP_FS);
    endfunction

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------

    logic setup_phase;
    logic access_phase;
    logic hit_coarse;
    logic hit_status;
    logic req_err;

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign hit_coarse   = addr_hit(paddr, `ADCR_OFS_COARSE);
    assign hit_status   = addr_hit(paddr, `ADCR_OFS_STATUS);

    // status is read-only, so a write there is answered with an error
    assign req_err = ~(hit_coarse | (hit_status & ~pwrite));

    // ------------------------------------------------------------------
    // effective delay selection
    // ------------------------------------------------------------------

    adcr_src_t src;
    logic      path_on;
    logic      local_ignored;

    always_comb begin
        if (fine_reg_delay_select) begin
            src = ADCR_SRC_FINE;
        end else if (rif.sel) begin
            src = ADCR_SRC_LOCAL;
        end else begin
            src = ADCR_SRC_NONE;
        end
    end

    assign path_on       = (src != ADCR_SRC_NONE);
    assign local_ignored = fine_reg_delay_select & rif.sel;

    // ------------------------------------------------------------------
    // status word
    // ------------------------------------------------------------------

    adcr_word_t status_word;

    always_comb begin
        status_word = '0;
        status_word[`ADCR_CODE_HI:`ADCR_CODE_LO] = applied_coarse_code;
        status_word[`ADCR_STS_SEL_BIT]           = delay_path_en;
        status_word[`ADCR_STS_FINE_BIT]          = fine_reg_delay_select;
        status_word[`ADCR_STS_SAT_BIT]           = is_sat(rif.code);
        status_word[`ADCR_STS_IGN_BIT]           = local_ignored;
    end

    // ------------------------------------------------------------------
    // write path with byte lanes
    // ------------------------------------------------------------------

    adcr_word_t merged;

    always_comb begin
        merged = rif.rd_word;
        if (pstrb[0]) begin
            merged[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
            merged[15:8] = pwdata[15:8];
        end
        // reserved bits are dropped even if software breaks the zero rule
        merged[`ADCR_RSVD_HI:`ADCR_RSVD_LO] = 2'b00;
    end

    assign rif.wr_en   = access_phase & pwrite & hit_coarse;
    assign rif.wr_data = merged;

    // ------------------------------------------------------------------
    // read data and error, captured in the setup cycle
    // ------------------------------------------------------------------

    logic [31:0] next_prdata;
    logic        err;
    logic        next_err;

    always_comb begin
        next_prdata = prdata;
        next_err    = err;
        if (setup_phase) begin
            next_err    = req_err;
            next_prdata = '0;
            if (!pwrite) begin
                if (hit_coarse) begin
                    next_prdata = {16'h0000, rif.rd_word};
                end else if (hit_status) begin
                    next_prdata = {16'h0000, status_word};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            err    <= 1'b0;
        end else begin
            prdata <= next_prdata;
            err    <= next_err;
        end
    end

    // every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = access_phase & err;

    // ------------------------------------------------------------------
    // applied delay outputs
    // ------------------------------------------------------------------

    adcr_code_t next_coarse;
    adcr_fine_t next_fine;
    logic       next_path_en;
    logic       next_dcc;
    adcr_fs_t   next_delay_fs;

    localparam adcr_word_t RESET_WORD = `ADCR_COARSE_RESET;

    always_comb begin
        next_path_en = path_on;
        next_dcc     = rif.dcc;
        if (path_on) begin
            next_coarse = sat_code(rif.code);
            next_fine   = fine_delay_code;
        end else begin
            next_coarse = '0;
            next_fine   = '0;
        end
        next_delay_fs = delay_fs(next_coarse, next_fine);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            applied_coarse_code      <= '0;
            applied_fine_code        <= '0;
            delay_path_en            <= 1'b0;
            duty_cycle_stabilizer_en <= RESET_WORD[`ADCR_DCC_BIT];
            applied_delay_fs         <= '0;
        end else begin
            applied_coarse_code      <= next_coarse;
            applied_fine_code        <= next_fine;
            delay_path_en            <= next_path_en;
            duty_cycle_stabilizer_en <= next_dcc;
            applied_delay_fs         <= next_delay_fs;
        end
    end

endmodule

// [verification/adcr_top_chk.sv]
// port assertions for the coarse delay register block
`timescale 1ns/1ps
`include "adcr_cfg.svh"
module adcr_top_chk (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [`ADCR_ADDR_W-1:0]  paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [3:0]               pstrb,
    input wire logic                     fine_reg_delay_select,
    input wire logic [`ADCR_FINE_W-1:0]  fine_delay_code,
    input wire logic [`ADCR_CODE_W-1:0]  applied_coarse_code,
    input wire logic [`ADCR_FINE_W-1:0]  applied_fine_code,
    input wire logic                     delay_path_en,
    input wire logic                     duty_cycle_stabilizer_en,
    input wire logic [`ADCR_FS_W-1:0]    applied_delay_fs
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    function automatic logic [11:0] sat(input logic [11:0] c);
        return (c > 12'd2431) ? 12'd2431 : c;
    endfunction
    sequence s_wr;
        psel && penable && pwrite && paddr == `ADCR_OFS_COARSE && pstrb[1:0] == 2'b11;
    endsequence
    property p_fine_sel; fine_reg_delay_select |=> delay_path_en; endproperty
    property p_off; !delay_path_en |-> applied_coarse_code == 0 && applied_fine_code == 0;
    endproperty
    property p_sat; s_wr ##0 pwdata[3] |-> ##2 applied_coarse_code == sat($past(pwdata[15:4], 2));
    endproperty
    property p_sel_on; s_wr ##0 pwdata[3] |-> ##2 delay_path_en; endproperty
    property p_dcc; s_wr |-> ##2 duty_cycle_stabilizer_en == $past(pwdata[2], 2); endproperty
    property p_fine; delay_path_en |-> applied_fine_code == $past(fine_delay_code); endproperty
    property p_fs;
        applied_delay_fs == {8'h00, applied_coarse_code} * 20'd340
                          + {14'h0000, applied_fine_code} * 20'd36;
    endproperty
    property p_local_off; s_wr ##0 !pwdata[3] ##1 !fine_reg_delay_select |=> !delay_path_en;
    endproperty
    a_fine_sel: assert property (p_fine_sel) else $error("path off with fine select");
    a_off: assert property (p_off) else $error("codes applied with path off");
    a_sat: assert property (p_sat) else $error("coarse code not saturated");
    a_sel_on: assert property (p_sel_on) else $error("local select did not enable");
    a_dcc: assert property (p_dcc) else $error("stabilizer bit not followed");
    a_fine: assert property (p_fine) else $error("fine code not applied");
    a_fs: assert property (p_fs) else $error("delay sum wrong");
    a_local_off: assert property (p_local_off) else $error("path on with no select");
endmodule

bind adcr_top adcr_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .fine_reg_delay_select(fine_reg_delay_select), .fine_delay_code(fine_delay_code),
    .applied_coarse_code(applied_coarse_code), .applied_fine_code(applied_fine_code),
    .delay_path_en(delay_path_en), .duty_cycle_stabilizer_en(duty_cycle_stabilizer_en),
    .applied_delay_fs(applied_delay_fs));

// [verification/aperture_delay_coarse_reg_tb.sv]
// self-checking bench for the coarse delay register block
`timescale 1ns/1ps
`include "adcr_cfg.svh"
module aperture_delay_coarse_reg_tb
    import adcr_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, lf = 32'd76264;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, fsel = 0, er, delay_path_en, duty_cycle_stabilizer_en;
    adcr_fine_t  fcode = 0, applied_fine_code;
    adcr_code_t  applied_coarse_code;
    adcr_fs_t    applied_delay_fs;
    int          n_mismatch = 0, checks = 0, model;
    int          codes[5] = '{0, 1, 2431, 2432, 4095};

    always #12.5 pclk = ~pclk;

    adcr_top u_adcr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fine_reg_delay_select(fsel),
        .fine_delay_code(fcode), .applied_coarse_code(applied_coarse_code),
        .applied_fine_code(applied_fine_code), .delay_path_en(delay_path_en),
        .duty_cycle_stabilizer_en(duty_cycle_stabilizer_en),
        .applied_delay_fs(applied_delay_fs));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic check_outs;
        int code, path, ac, af, sts;
        code = model >> 4;
        path = ((model >> 3) & 1) | fsel;
        ac = path ? ((code > 2431) ? 2431 : code) : 0;
        af = path ? fcode : 0;
        sts = ac * 16 + path * 8 + fsel * 4 + ((code > 2431) ? 2 : 0) + ((model >> 3) & fsel & 1);
        chk("path_en", delay_path_en, path);
        chk("coarse", applied_coarse_code, ac);
        chk("fine", applied_fine_code, af);
        chk("stabilizer", duty_cycle_stabilizer_en, (model >> 2) & 1);
        chk("delay_fs", applied_delay_fs, ac * 340 + af * 36);
        apb(0, `ADCR_OFS_COARSE, 0);
        chk("readback", rd, model);
        apb(0, `ADCR_OFS_STATUS, 0);
        chk("status", rd, sts);
    endtask

    task automatic wr_chk(input logic [31:0] d);
        apb(1, `ADCR_OFS_COARSE, d & 32'h0000_fffc);
        chk("write_err", er, 0);
        model = d & 32'h0000_fffc;
        repeat (2) @(posedge pclk);
        check_outs();
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        model = 16'h0004;
        check_outs();
        $display("test reset done");
        // every select combination at the saturation boundary codes
        foreach (codes[k]) begin
            for (int i = 0; i < 4; i++) begin
                lf = lfsr(lf);
                fsel <= i[1];
                fcode <= lf[5:0];
                wr_chk({16'h0, codes[k][11:0], i[0], i != 2, 2'b00});
            end
        end
        $display("test boundary codes done");
        repeat (24) begin
            lf = lfsr(lf);
            fsel <= lf[20];
            fcode <= lf[27:22];
            wr_chk({16'h0, lf[15:0]});
        end
        $display("test random done");
        apb(1, 12'h020, 32'hffff);
        chk("unmapped_wr_err", er, 1);
        apb(0, 12'h020, 0);
        chk("unmapped_rd_err", er, 1);
        chk("unmapped_rd", rd, 0);
        apb(1, `ADCR_OFS_STATUS, 32'hfff8);
        chk("status_wr_err", er, 1);
        check_outs();
        $display("test refused done");
        // only the low byte lane is written, the high byte keeps its value
        pstrb <= 4'h1;
        apb(1, `ADCR_OFS_COARSE, 32'h0000_a5c8);
        pstrb <= 4'hf;
        chk("lane_write_err", er, 0);
        model = (model & 32'h0000_ff00) | 32'h0000_00c8;
        repeat (2) @(posedge pclk);
        check_outs();
        $display("test byte lanes done");
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        model = 16'h0004;
        check_outs();
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
